// ### rtl/atf_pkg.sv
// Package of constants for the task-file register port
package atf_pkg;
   // ----------------------------------------
   // Register addresses (cs2_n, cs1_n, da)
   // ----------------------------------------
   localparam logic [2:0] A_DATA        = 3'h0;
   localparam logic [2:0] A_FEAT_ERR    = 3'h1;
   localparam logic [2:0] A_INT_REASON  = 3'h2;
   localparam logic [2:0] A_SECTOR_CNT  = 3'h3;
   localparam logic [2:0] A_BCNT_LOW    = 3'h4;
   localparam logic [2:0] A_BCNT_HIGH   = 3'h5;
   localparam logic [2:0] A_DRIVE_SEL   = 3'h6;
   localparam logic [2:0] A_CMD_STAT    = 3'h7;
   localparam logic [2:0] A_DEV_CTRL    = 3'h6;
   localparam logic [2:0] A_DRIVE_ADDR  = 3'h7;
   // ----------------------------------------
   // Field positions and values
   // ----------------------------------------
   localparam int         DRV_BIT       = 4;
   localparam int         BSY_BIT       = 7;
   localparam int         SRST_BIT      = 2;
   localparam int         NIEN_BIT      = 1;
   localparam int         FLOAT_BIT     = 7;
   localparam logic [2:0] DSEL_ONES     = 3'h7;
   localparam logic [7:0] CMD_DIAG      = 8'h90;
   localparam logic [7:0] STAT_RESET    = 8'h80;
   localparam logic [7:0] DCTRL_RESET   = 8'h08;
   localparam int         FIFO_DEPTH    = 4;
endpackage

// ### rtl/atf_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module atf_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rstn,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
      inc = (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
   endfunction

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= inc(wr_ptr);
         end
         if (pop) begin
            rd_ptr <= inc(rd_ptr);
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // atf_fifo

// ### rtl/atf_task_file.sv
// Task-file register port of the drive: host register decode and events
// Functional notes
// - Decode two chip selects and three address lines; data 16 bits, others 8.
// - A 16-bit data register moves transfer data both ways.
// - Drive is selected only while drive-select bit 4 equals own drive number.
// - Host interrupt output is enabled only while selected.
// - Drive-select reads ones in bits 7..5, drive bit at bit 4.
// - Command write while selected raises command interrupt to sub-CPU.
// - Diagnostic command 90h raises command interrupt and busy even unselected.
// - Write to command/status address clears a pending host interrupt.
// - Busy set on selected command, diagnostic, soft reset and hardware reset.
// - Alternate status equals status; reading it leaves host interrupt alone.
// - Soft-reset bit going 0 to 1 raises soft-reset interrupt and sets busy.
// - Interrupt pin driven only when disable bit low and selected, else floats.
// - Drive address read leaves data bit 7 undriven.
`timescale 1ns/100ps
module atf_task_file
   import atf_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rstn,
   // Host bus pins
   input  wire logic        cs1_n,
   input  wire logic        cs2_n,
   input  wire logic [2:0]  da,
   input  wire logic        hrd_n,
   input  wire logic        hwr_n,
   input  wire logic [15:0] hdata_in,
   output logic      [15:0] hdata_out,
   output logic      [15:0] hdata_oe_n,
   output logic             hint_out,
   output logic             hint_oe_n,
   // Sub-CPU side
   input  wire logic        own_drive_number,
   input  wire logic        transfer_active,
   input  wire logic        host_irq_set,
   input  wire logic [7:0]  status_load,
   input  wire logic        status_load_en,
   input  wire logic [7:0]  error_read,
   input  wire logic [7:0]  drive_address_readback,
   input  wire logic [7:0]  interrupt_reason_load,
   input  wire logic        interrupt_reason_load_en,
   output logic             command_irq_to_sub_cpu,
   output logic             soft_reset_irq_to_sub_cpu,
   output logic      [7:0]  task_command,
   output logic      [7:0]  features_write,
   output logic      [7:0]  sector_count,
   output logic      [7:0]  byte_count_low,
   output logic      [7:0]  byte_count_high,
   output logic      [7:0]  device_control,
   output logic      [7:0]  task_status,
   // Data stream from host to sub-CPU
   output logic             wdata_valid,
   input  wire logic        wdata_ready,
   output logic      [15:0] wdata,
   // Data stream from sub-CPU to host
   input  wire logic [15:0] transfer_data_word,
   output logic             rdata_taken
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [5:0]  ctl_s1;
   logic [5:0]  ctl_s2;
   logic [15:0] dat_s1;
   logic [15:0] dat_s2;
   logic        drv_s1;
   logic        drv_s2;
   logic        hrd_prev;
   logic        hwr_prev;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctl_s1 <= 6'h3f;
         ctl_s2 <= 6'h3f;
         dat_s1 <= 16'h0000;
         dat_s2 <= 16'h0000;
         drv_s1 <= 1'b0;
         drv_s2 <= 1'b0;
      end else begin
         ctl_s1 <= {cs2_n, cs1_n, da, hrd_n};
         ctl_s2 <= ctl_s1;
         dat_s1 <= hdata_in;
         dat_s2 <= dat_s1;
         drv_s1 <= own_drive_number;
         drv_s2 <= drv_s1;
      end
   end

   logic [2:0] addr;
   logic       sel_cmd;
   logic       sel_ctl;
   logic       rd_lvl;
   logic       wr_lvl;
   logic       hwr_s1;
   logic       hwr_s2;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         hwr_s1 <= 1'b1;
         hwr_s2 <= 1'b1;
      end else begin
         hwr_s1 <= hwr_n;
         hwr_s2 <= hwr_s1;
      end
   end

   // Command block: cs1_n low, cs2_n high; control block the reverse
   assign addr    = ctl_s2[3:1];
   assign sel_cmd = ctl_s2[5] && !ctl_s2[4];
   assign sel_ctl = !ctl_s2[5] && ctl_s2[4];
   assign rd_lvl  = !ctl_s2[0];
   assign wr_lvl  = !hwr_s2;

   // ----------------------------------------
   // Strobe edges
   // ----------------------------------------
   // Both strobes idle high, so the history starts inactive after reset

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         hrd_prev <= 1'b0;
         hwr_prev <= 1'b0;
      end else begin
         hrd_prev <= rd_lvl;
         hwr_prev <= wr_lvl;
      end
   end

   // Act once per strobe: reads on leading edge, writes on trailing edge
   // so the data bus has settled for the whole pulse.
   logic rd_start;
   logic wr_end;
   assign rd_start = rd_lvl && !hrd_prev;
   assign wr_end   = !wr_lvl && hwr_prev;

   function automatic logic hit(input logic sel, input logic [2:0] a,
                                input logic [2:0] want);
      hit = sel && (a == want);
   endfunction

   // ----------------------------------------
   // Write capture
   // ----------------------------------------
   // Address latched while the write strobe is low
   logic [2:0] waddr;
   logic       wsel_cmd;
   logic       wsel_ctl;
   logic [15:0] wval;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         waddr    <= 3'h0;
         wsel_cmd <= 1'b0;
         wsel_ctl <= 1'b0;
         wval     <= 16'h0000;
      end else if (wr_lvl) begin
         waddr    <= addr;
         wsel_cmd <= sel_cmd;
         wsel_ctl <= sel_ctl;
         wval     <= dat_s2;
      end
   end

   // ----------------------------------------
   // Selection and writable registers
   // ----------------------------------------
   logic drv_bit;
   logic selected;
   logic cmd_wr;
   logic diag_wr;
   logic srst_rise;
   logic stat_rd;

   assign selected = (drv_bit == drv_s2);
   assign cmd_wr   = wr_end && hit(wsel_cmd, waddr, A_CMD_STAT);
   // Diagnostic reaches both drives on the cable, selected or not
   assign diag_wr  = cmd_wr && (wval[7:0] == CMD_DIAG);
   // Only the 0 to 1 step of the soft-reset bit counts, so rewriting the
   // register with the bit still high does not retrigger the sub-CPU
   assign srst_rise = wr_end && hit(wsel_ctl, waddr, A_DEV_CTRL)
                      && wval[SRST_BIT] && !device_control[SRST_BIT];
   // Alternate status lives in the control block and never clears
   assign stat_rd  = rd_start && hit(sel_cmd, addr, A_CMD_STAT);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         drv_bit         <= 1'b0;
         task_command    <= 8'h00;
         features_write  <= 8'h00;
         sector_count    <= 8'h00;
         byte_count_low  <= 8'h00;
         byte_count_high <= 8'h00;
         device_control  <= DCTRL_RESET;
      end else if (wr_end) begin
         if (wsel_cmd) begin
            unique case (waddr)
               A_FEAT_ERR:   features_write  <= wval[7:0];
               A_SECTOR_CNT: sector_count    <= wval[7:0];
               A_BCNT_LOW:   byte_count_low  <= wval[7:0];
               A_BCNT_HIGH:  byte_count_high <= wval[7:0];
               A_DRIVE_SEL:  drv_bit         <= wval[DRV_BIT];
               A_CMD_STAT:   task_command    <= wval[7:0];
               default:      ;
            endcase
         end
         // Reserved bits are stored as written; host keeps bit 3 set
         if (hit(wsel_ctl, waddr, A_DEV_CTRL)) begin
            device_control <= wval[7:0];
         end
      end
   end

   // Sub-CPU load wins over a host write in the same cycle
   logic [7:0] int_reason;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         int_reason <= 8'h00;
      end else if (interrupt_reason_load_en) begin
         int_reason <= interrupt_reason_load;
      end else if (wr_end && hit(wsel_cmd, waddr, A_INT_REASON)) begin
         int_reason <= wval[7:0];
      end
   end

   // ----------------------------------------
   // Status, busy and interrupts
   // ----------------------------------------
   // Busy set wins over a sub-CPU status load in the same cycle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         task_status <= STAT_RESET;
      end else begin
         if (status_load_en) begin
            task_status <= status_load;
         end
         if ((cmd_wr && selected) || diag_wr || srst_rise) begin
            task_status[BSY_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         command_irq_to_sub_cpu    <= 1'b0;
         soft_reset_irq_to_sub_cpu <= 1'b0;
      end else begin
         command_irq_to_sub_cpu    <= (cmd_wr && selected) || diag_wr;
         soft_reset_irq_to_sub_cpu <= srst_rise;
      end
   end

   // ----------------------------------------
   // Host interrupt
   // ----------------------------------------
   // Set wins over a clear arriving in the same cycle
   logic host_irq;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         host_irq <= 1'b0;
      end else if (host_irq_set) begin
         host_irq <= 1'b1;
      end else if (cmd_wr || stat_rd) begin
         host_irq <= 1'b0;
      end
   end

   // Tri-state: enable low means driving
   assign hint_out  = host_irq;
   assign hint_oe_n = !(selected && !device_control[NIEN_BIT]);

   // ----------------------------------------
   // Data path
   // ----------------------------------------
   // Data writes before the sub-CPU starts a transfer are discarded
   logic data_wr;
   assign data_wr = wr_end && hit(wsel_cmd, waddr, A_DATA) && transfer_active;

   // Writes past a full FIFO are dropped; the sub-CPU paces the host
   atf_fifo #(
      .WIDTH (16),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clock     (clock),
      .rstn      (rstn),
      .in_valid  (data_wr),
      .in_ready  (),
      .in_data   (wval),
      .out_valid (wdata_valid),
      .out_ready (wdata_ready),
      .out_data  (wdata)
   );

   assign rdata_taken = rd_start && hit(sel_cmd, addr, A_DATA) && transfer_active;

   // ----------------------------------------
   // Host register reads
   // ----------------------------------------
   // Read data is registered, so it follows the strobe by one cycle;
   // the lag keeps the pins free of decode glitches
   logic [15:0] next_rd;
   logic [15:0] next_oe_n;
   always_comb begin
      next_rd   = 16'h0000;
      next_oe_n = 16'hffff;
      if (rd_lvl && sel_cmd) begin
         next_oe_n = 16'hff00;
         unique case (addr)
            A_DATA: begin
               next_rd   = transfer_data_word;
               next_oe_n = 16'h0000;
            end
            A_FEAT_ERR:   next_rd[7:0] = error_read;
            A_INT_REASON: next_rd[7:0] = int_reason;
            A_SECTOR_CNT: next_rd[7:0] = sector_count;
            A_BCNT_LOW:   next_rd[7:0] = byte_count_low;
            A_BCNT_HIGH:  next_rd[7:0] = byte_count_high;
            A_DRIVE_SEL:  next_rd[7:0] = {DSEL_ONES, drv_bit, 4'h0};
            A_CMD_STAT:   next_rd[7:0] = task_status;
         endcase
      end else if (rd_lvl && sel_ctl && addr == A_DEV_CTRL) begin
         next_rd[7:0] = task_status;
         next_oe_n    = 16'hff00;
      end else if (rd_lvl && sel_ctl && addr == A_DRIVE_ADDR) begin
         next_rd[7:0] = drive_address_readback;
         next_oe_n    = 16'hff00;
         next_oe_n[FLOAT_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         hdata_out  <= 16'h0000;
         hdata_oe_n <= 16'hffff;
      end else begin
         hdata_out  <= next_rd;
         hdata_oe_n <= next_oe_n;
      end
   end
endmodule // atf_task_file

// ### tb/atf_task_file_asserts.sv
// Checker for the task-file port, bound to the atf_task_file module
`timescale 1ns/100ps
module atf_task_file_asserts
   import atf_pkg::*;
(
   // Clock and reset
   input wire logic        clock,
   input wire logic        rstn,
   // Watched outputs and handshake
   input wire logic        hint_oe_n,
   input wire logic [15:0] hdata_oe_n,
   input wire logic [7:0]  device_control,
   input wire logic [7:0]  task_status,
   input wire logic        command_irq_to_sub_cpu,
   input wire logic        soft_reset_irq_to_sub_cpu,
   input wire logic        wdata_valid,
   input wire logic        wdata_ready,
   input wire logic [15:0] wdata,
   input wire logic        rdata_taken
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   property p_hint_en; !hint_oe_n |-> !device_control[NIEN_BIT]; endproperty
   a_hint_en: assert property (p_hint_en) else $error("interrupt pin driven while disabled");
   property p_cmd_busy; command_irq_to_sub_cpu |-> task_status[BSY_BIT]; endproperty
   a_cmd_busy: assert property (p_cmd_busy) else $error("command event without busy");
   property p_cmd_pulse; command_irq_to_sub_cpu |=> !command_irq_to_sub_cpu; endproperty
   a_cmd_pulse: assert property (p_cmd_pulse) else $error("command event too long");
   property p_srst; soft_reset_irq_to_sub_cpu |-> task_status[BSY_BIT] && device_control[SRST_BIT]; endproperty
   a_srst: assert property (p_srst) else $error("soft reset event without cause");
   property p_srst_edge; $rose(device_control[SRST_BIT]) |-> ##[0:2] soft_reset_irq_to_sub_cpu; endproperty
   a_srst_edge: assert property (p_srst_edge) else $error("soft reset event missing");
   property p_fifo_hold; wdata_valid && !wdata_ready |=> wdata_valid && $stable(wdata); endproperty
   a_fifo_hold: assert property (p_fifo_hold) else $error("stalled word changed");
   property p_wide; !hdata_oe_n[15] |-> hdata_oe_n == 16'h0000; endproperty
   a_wide: assert property (p_wide) else $error("upper byte driven on byte read");
   property p_float; !hdata_oe_n[0] && hdata_oe_n[FLOAT_BIT] |-> &hdata_oe_n[15:8]; endproperty
   a_float: assert property (p_float) else $error("floating bit read drove upper byte");
   property p_rst_busy; $rose(rstn) |-> task_status[BSY_BIT]; endproperty
   a_rst_busy: assert property (p_rst_busy) else $error("busy clear after reset");
   property p_rd_pulse; rdata_taken |=> !rdata_taken; endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("data read marker too long");
endmodule // atf_task_file_asserts

bind atf_task_file atf_task_file_asserts chk_u (.*);

// ### tb/atf_host_model.sv
// Host adapter model driving the task-file bus
`timescale 1ns/100ps
module atf_host_model (
   // Clock
   input  wire logic        clock,
   // Host bus
   output logic             cs1_n,
   output logic             cs2_n,
   output logic [2:0]       da,
   output logic             hrd_n,
   output logic             hwr_n,
   output logic [15:0]      hdata_in,
   input  wire logic [15:0] hdata_out,
   input  wire logic [15:0] hdata_oe_n
);
   logic [15:0] bus;
   logic        rd_done;
   logic [15:0] rd_val;
   // Pull-ups hold undriven data bits high
   assign bus = (hdata_out & ~hdata_oe_n) | hdata_oe_n;
   initial begin
      {cs1_n, cs2_n, hrd_n, hwr_n, rd_done} = 5'b11110;
      da = 3'h0;
      hdata_in = 16'h0000;
      rd_val = 16'h0000;
   end
   // ctl selects the control block, else the command block
   task automatic wr(input logic ctl, input logic [2:0] a, input logic [15:0] d);
      @(posedge clock);
      cs1_n <= ctl;
      cs2_n <= ~ctl;
      da <= a;
      hdata_in <= d;
      hwr_n <= 1'b0;
      repeat (4) @(posedge clock);
      hwr_n <= 1'b1;
      repeat (4) @(posedge clock);
      {cs1_n, cs2_n} <= 2'b11;
      // Released data shows no stale value
      hdata_in <= ~d;
      repeat (4) @(posedge clock);
   endtask
   task automatic rd(input logic ctl, input logic [2:0] a);
      @(posedge clock);
      cs1_n <= ctl;
      cs2_n <= ~ctl;
      da <= a;
      hrd_n <= 1'b0;
      repeat (6) @(posedge clock);
      rd_val <= bus;
      rd_done <= 1'b1;
      hrd_n <= 1'b1;
      {cs1_n, cs2_n} <= 2'b11;
      @(posedge clock);
      rd_done <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
endmodule // atf_host_model

// ### tb/atf_task_file_tb_top.sv
// Self-checking testbench of the task-file port
`timescale 1ns/100ps
module atf_task_file_tb_top;
   import atf_pkg::*;
   logic        clock, rstn, cs1_n, cs2_n, hrd_n, hwr_n, hint_out, hint_oe_n;
   logic [2:0]  da;
   logic [15:0] hdata_in, hdata_out, hdata_oe_n, wdata, transfer_data_word;
   logic        own_drive_number, transfer_active, host_irq_set, status_load_en;
   logic        interrupt_reason_load_en, command_irq_to_sub_cpu, soft_reset_irq_to_sub_cpu;
   logic        wdata_valid, wdata_ready, rdata_taken;
   logic [7:0]  status_load, error_read, drive_address_readback, interrupt_reason_load;
   logic [7:0]  task_command, features_write, sector_count, byte_count_low;
   logic [7:0]  byte_count_high, device_control, task_status, r8;
   logic [15:0] q[$];
   logic [15:0] seen, w;
   int          err_count, num_checks, n_taken;
   atf_task_file dut_u (.*);
   atf_host_model host_u (.*);
   always #12.5 clock = ~clock;
   task automatic check(input logic [15:0] s, input logic [15:0] e);
      num_checks++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic sub_status(input logic [7:0] v);
      status_load <= v;
      status_load_en <= 1'b1;
      @(posedge clock);
      status_load_en <= 1'b0;
   endtask
   // ----------------------------------------
   // Result monitor: oldest note against each result
   // ----------------------------------------
   always @(posedge clock) begin
      if (host_u.rd_done || wdata_valid && wdata_ready || command_irq_to_sub_cpu
          || soft_reset_irq_to_sub_cpu) begin
         if (host_u.rd_done) seen = host_u.rd_val;
         else if (wdata_valid && wdata_ready) seen = wdata;
         else if (command_irq_to_sub_cpu) seen = {task_status, task_command};
         else seen = {task_status, device_control};
         if (q.size() == 0) check({15'h0000, 1'b1}, 16'h0000);
         else check(seen, q.pop_front());
      end
   end
   always @(posedge clock) begin
      if (rdata_taken) n_taken++;
   end
   initial begin
      repeat (6000) @(posedge clock);
      err_count++;
      complete_run;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {clock, rstn, own_drive_number, transfer_active, host_irq_set} = 5'b00000;
      {status_load_en, interrupt_reason_load_en, wdata_ready} = 3'b000;
      {status_load, error_read, drive_address_readback, interrupt_reason_load} = 32'h0000_0000;
      transfer_data_word = 16'h0000;
      err_count = 0;
      num_checks = 0;
      n_taken = 0;
      void'($urandom(32'hb89c));
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(posedge clock);
      check({8'h00, task_status}, {8'h00, STAT_RESET});
      sub_status(8'h00);
      host_u.wr(0, A_DRIVE_SEL, 16'h0010);
      check({15'h0000, hint_oe_n}, 16'h0001);
      q.push_back(16'hfff0);
      host_u.rd(0, A_DRIVE_SEL);
      host_u.wr(0, A_CMD_STAT, 16'h00a0);
      check({8'h00, task_status}, 16'h0000);
      q.push_back({STAT_RESET, CMD_DIAG});
      host_u.wr(0, A_CMD_STAT, {8'h00, CMD_DIAG});
      $display("test unselected done");
      host_u.wr(0, A_DRIVE_SEL, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         r8 = 8'($urandom);
         sub_status(8'h00);
         q.push_back({STAT_RESET, r8});
         host_u.wr(0, A_CMD_STAT, {8'h00, r8});
      end
      sub_status(8'h00);
      q.push_back(16'h800c);
      host_u.wr(1, A_DEV_CTRL, 16'h000c);
      host_u.wr(1, A_DEV_CTRL, {8'h00, DCTRL_RESET});
      $display("test commands done");
      host_irq_set <= 1'b1;
      @(posedge clock);
      host_irq_set <= 1'b0;
      @(posedge clock);
      check({14'h0000, hint_oe_n, hint_out}, 16'h0001);
      own_drive_number <= 1'b1;
      repeat (4) @(posedge clock);
      check({15'h0000, hint_oe_n}, 16'h0001);
      own_drive_number <= 1'b0;
      repeat (4) @(posedge clock);
      q.push_back(16'hff80);
      host_u.rd(1, A_DEV_CTRL);
      check({15'h0000, hint_out}, 16'h0001);
      q.push_back(16'hff80);
      host_u.rd(0, A_CMD_STAT);
      check({15'h0000, hint_out}, 16'h0000);
      host_irq_set <= 1'b1;
      @(posedge clock);
      host_irq_set <= 1'b0;
      q.push_back(16'h8021);
      host_u.wr(0, A_CMD_STAT, 16'h0021);
      check({15'h0000, hint_out}, 16'h0000);
      host_u.wr(1, A_DEV_CTRL, 16'h000a);
      check({15'h0000, hint_oe_n}, 16'h0001);
      host_u.wr(1, A_DEV_CTRL, {8'h00, DCTRL_RESET});
      $display("test host interrupt done");
      wdata_ready <= 1'b1;
      host_u.wr(0, A_DATA, 16'h5a5a);
      transfer_active <= 1'b1;
      wdata_ready <= 1'b0;
      for (int i = 0; i <= FIFO_DEPTH; i++) begin
         w = 16'($urandom);
         if (i < FIFO_DEPTH) q.push_back(w);
         host_u.wr(0, A_DATA, w);
      end
      repeat (40) @(posedge clock) wdata_ready <= 1'($urandom);
      wdata_ready <= 1'b1;
      w = 16'($urandom);
      transfer_data_word <= w;
      q.push_back(w);
      host_u.rd(0, A_DATA);
      $display("test data done");
      w = 16'($urandom);
      host_u.wr(0, A_FEAT_ERR, w);
      host_u.wr(0, A_SECTOR_CNT, {w[7:0], w[15:8]});
      host_u.wr(0, A_BCNT_LOW, w);
      host_u.wr(0, A_BCNT_HIGH, ~w);
      check({features_write, sector_count}, {w[7:0], w[15:8]});
      check({byte_count_high, byte_count_low}, {~w[7:0], w[7:0]});
      q.push_back({8'hff, w[15:8]});
      host_u.rd(0, A_SECTOR_CNT);
      q.push_back({8'hff, ~w[7:0]});
      host_u.rd(0, A_BCNT_HIGH);
      host_u.wr(0, A_INT_REASON, {8'h00, w[15:8]});
      q.push_back({8'hff, w[15:8]});
      host_u.rd(0, A_INT_REASON);
      interrupt_reason_load <= w[7:0];
      interrupt_reason_load_en <= 1'b1;
      @(posedge clock);
      interrupt_reason_load_en <= 1'b0;
      q.push_back({8'hff, w[7:0]});
      host_u.rd(0, A_INT_REASON);
      $display("test registers done");
      r8 = 8'($urandom);
      error_read <= r8;
      drive_address_readback <= ~r8;
      q.push_back({8'hff, r8});
      host_u.rd(0, A_FEAT_ERR);
      q.push_back({8'hff, 1'b1, ~r8[6:0]});
      host_u.rd(1, A_DRIVE_ADDR);
      $display("test read sources done");
      check(16'(q.size()), 16'h0000);
      check(16'(n_taken), 16'h0001);
      complete_run;
   end
endmodule // atf_task_file_tb_top
